// *** hw/sep_eeprom.sv ***
// Behaviour
// R01: status byte: enable, zeros, protect bits, latch, busy
// R02: refuse array writes inside protected block range
// R03: status write needs latch and pin permission
// R04: latch starts cleared after reset
// R05: set-latch takes effect at chip select rise
// R06: clear-latch command resets the latch
// R07: opcode, 16-bit address, data; low bits used
// R08: programming starts at closing chip select rise
// R09: during write cycle only status read answered
// R10: busy flag high for whole write cycle
// R11: page load wraps inside the 32-byte page
// R12: latch clears when write cycle completes
// R13: status write changes only bits 7, 3, 2
// R14: protect pin fall abandons pending status write
// R15: started status write always completes
// R16: pin ignored while pin enable is zero
// R17: read streams bytes, address wraps to zero
// R18: read runs until chip select rises
// R19: status read any time, all ones while busy
// R20: pause floats output and freezes transfer
// R21: host moves pause only with clock low
// R22: unknown opcode ignored, output stays floating
// R23: opcode encodings as listed
// R24: sample on rising, shift out on falling
// R25: write cycle lasts at most 5 ms
// R26: partial data byte discards the write
`timescale 1ns/1ns
module sep_eeprom #(
  parameter int WRITE_CYCLES = sep_pkg::WC_CYCLES
) (
  // system side
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // serial link pins
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  input  wire logic hold_n_in,
  input  wire logic wp_n_in,
  output logic      so_out,
  output logic      so_oe_out
);

  // =================================================================
  // storage
  // =================================================================
  // array is written only in the clock domain while busy, and read by
  // the link only when not busy, so the crossing read sees still data
  logic [7:0] mem      [sep_pkg::MEM_DEPTH];
  logic [7:0] page_buf [sep_pkg::PAGE_BYTES];

  // status bits held in the clock domain
  logic       pin_en;
  logic [1:0] bp;
  logic       latch;
  logic       busy;
  logic [7:0] status_byte;

  assign status_byte = {pin_en, 3'h0, bp, latch, busy};  // [R01]

  // =================================================================
  // link domain, rising edge of the serial clock
  // =================================================================
  typedef enum logic [2:0] {
    L_OPC,
    L_ADDR,
    L_DATA,
    L_READ,
    L_STAT,
    L_IGNORE
  } sep_link_e;

  sep_link_e                       lstate;
  sep_link_e                       next_lstate;
  logic [3:0]                      cnt;
  logic [3:0]                      next_cnt;
  logic [7:0]                      shreg;
  logic [7:0]                      next_shreg;
  logic [15:0]                     addr_sh;
  logic [15:0]                     next_addr_sh;
  logic [sep_pkg::ADDR_BITS-1:0]   ptr;
  logic [sep_pkg::ADDR_BITS-1:0]   next_ptr;
  logic [7:0]                      tx_byte;
  logic [7:0]                      next_tx_byte;
  logic                            tx_load;
  logic                            next_tx_load;
  logic                            tx_active;
  logic                            next_tx_active;
  // frame results, kept across chip select high for the clock domain
  sep_pkg::sep_kind_e              res_kind;
  sep_pkg::sep_kind_e              next_res_kind;
  logic [sep_pkg::ADDR_BITS-1:0]   res_addr;
  logic [sep_pkg::ADDR_BITS-1:0]   next_res_addr;
  logic [7:0]                      res_stat;
  logic [7:0]                      next_res_stat;
  logic                            res_partial;
  logic                            next_res_partial;
  logic                            res_got;
  logic                            next_res_got;
  logic [sep_pkg::PAGE_BYTES-1:0]  loaded;
  logic [sep_pkg::PAGE_BYTES-1:0]  next_loaded;
  logic                            buf_we;
  logic [sep_pkg::PAGE_BITS-1:0]   buf_idx;
  logic                            busy_l1;
  logic                            busy_l2;
  logic [7:0]                      in_byte;
  logic [sep_pkg::ADDR_BITS-1:0]   full_addr;

  assign in_byte   = {shreg[6:0], si_in};
  assign full_addr = {addr_sh[sep_pkg::ADDR_BITS-2:0], si_in};  // [R07]
  assign buf_idx   = ptr[sep_pkg::PAGE_BITS-1:0];

  // next values of the frame logic
  always_comb begin
    next_lstate      = lstate;
    next_cnt         = cnt;
    next_shreg       = shreg;
    next_addr_sh     = addr_sh;
    next_ptr         = ptr;
    next_tx_byte     = tx_byte;
    next_tx_load     = 1'b0;
    next_tx_active   = tx_active;
    next_res_kind    = res_kind;
    next_res_addr    = res_addr;
    next_res_stat    = res_stat;
    next_res_partial = res_partial;
    next_res_got     = res_got;
    next_loaded      = loaded;
    buf_we           = 1'b0;
    // edges while deselected, such as a mode change, leave results alone
    if (hold_n_in && !cs_n_in) begin       // paused edges do nothing [R20]
      next_shreg = in_byte;                // sample on rising edge [R24]
      next_cnt   = cnt + 4'h1;
      case (lstate)
        L_OPC: begin
          // only the kind is dropped here: load state must survive a
          // frame that arrives while the last page is still programming
          if (cnt == 4'h0) begin
            next_res_kind = sep_pkg::K_NONE;
          end
          if (cnt[2:0] == sep_pkg::BIT_LAST) begin
            next_cnt    = 4'h0;
            next_lstate = L_IGNORE;        // unknown opcode [R22]
            if (in_byte == sep_pkg::OPC_READ_STATUS) begin
              next_lstate    = L_STAT;     // answered even when busy [R19]
              next_tx_byte   = busy_l2 ? sep_pkg::ST_ALL_ONES : status_byte;
              next_tx_load   = 1'b1;
              next_tx_active = 1'b1;
            end else if (!busy_l2) begin   // others ignored while busy [R09]
              case (in_byte)               // decode [R23]
                sep_pkg::OPC_SET_LATCH: begin
                  next_res_kind = sep_pkg::K_SET;
                end
                sep_pkg::OPC_CLEAR_LATCH: begin
                  next_res_kind = sep_pkg::K_CLEAR;
                end
                sep_pkg::OPC_WRITE_STAT: begin
                  next_res_kind    = sep_pkg::K_WSTAT;
                  next_lstate      = L_DATA;
                  next_res_partial = 1'b0;
                  next_res_got     = 1'b0;
                end
                sep_pkg::OPC_WRITE_ARRAY: begin
                  next_res_kind    = sep_pkg::K_WARRAY;
                  next_lstate      = L_ADDR;
                  next_res_partial = 1'b0;
                  next_res_got     = 1'b0;
                  next_loaded      = '0;   // not busy, buffer is free [R09]
                end
                sep_pkg::OPC_READ_ARRAY: begin
                  next_res_kind = sep_pkg::K_READ;
                  next_lstate   = L_ADDR;
                end
                default: begin
                  next_lstate = L_IGNORE;
                end
              endcase
            end
          end
        end
        L_ADDR: begin
          next_addr_sh = {addr_sh[14:0], si_in};
          if (cnt == sep_pkg::ADDR_LAST) begin
            next_cnt      = 4'h0;
            next_res_addr = full_addr;
            next_ptr      = full_addr;
            if (res_kind == sep_pkg::K_READ) begin
              next_lstate    = L_READ;     // first byte right away [R17]
              next_tx_byte   = mem[full_addr];
              next_tx_load   = 1'b1;
              next_tx_active = 1'b1;
              next_ptr       = full_addr + 10'h001;
            end else begin
              next_lstate = L_DATA;
            end
          end
        end
        L_DATA: begin
          next_res_partial = 1'b1;         // cleared on a whole byte [R26]
          if (cnt[2:0] == sep_pkg::BIT_LAST) begin
            next_cnt         = 4'h0;
            next_res_partial = 1'b0;
            next_res_got     = 1'b1;
            next_res_stat    = in_byte;
            buf_we           = (res_kind == sep_pkg::K_WARRAY);
            next_loaded[buf_idx] = 1'b1;
            // only the in-page bits advance, wrapping in the page [R11]
            next_ptr = {ptr[sep_pkg::ADDR_BITS-1:sep_pkg::PAGE_BITS],
                        buf_idx + 5'h01};
          end
        end
        L_READ, L_STAT: begin
          if (cnt[2:0] == sep_pkg::BIT_LAST) begin
            next_cnt     = 4'h0;
            next_tx_load = 1'b1;
            if (lstate == L_READ) begin
              next_tx_byte = mem[ptr];     // pointer wraps at top [R17]
              next_ptr     = ptr + 10'h001;
            end else begin
              next_tx_byte = busy_l2 ? sep_pkg::ST_ALL_ONES : status_byte;
            end
          end
        end
        L_IGNORE: begin
          next_cnt = 4'h0;
        end
        default: begin
          next_lstate = L_IGNORE;
        end
      endcase
    end
  end

  // frame state restarts whenever chip select is high [R18]
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lstate    <= L_OPC;
      cnt       <= 4'h0;
      tx_load   <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      lstate    <= next_lstate;
      cnt       <= next_cnt;
      tx_load   <= next_tx_load;
      tx_active <= next_tx_active;
    end
  end

  // data and results that must outlive the frame
  always_ff @(posedge sck_in) begin
    shreg       <= next_shreg;
    addr_sh     <= next_addr_sh;
    ptr         <= next_ptr;
    tx_byte     <= next_tx_byte;
    res_kind    <= next_res_kind;
    res_addr    <= next_res_addr;
    res_stat    <= next_res_stat;
    res_partial <= next_res_partial;
    res_got     <= next_res_got;
    loaded      <= next_loaded;
    busy_l1     <= busy;
    busy_l2     <= busy_l1;
    if (buf_we) begin
      page_buf[buf_idx] <= in_byte;
    end
  end

  // =================================================================
  // link domain, falling edge: serial output
  // =================================================================
  logic [7:0] out_sr;

  // shift out on the falling edge [R24]; deselect parks the line low
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_out <= 1'b0;
      out_sr <= 8'h00;
    end else if (hold_n_in) begin
      if (tx_load) begin
        so_out <= tx_byte[7];
        out_sr <= {tx_byte[6:0], 1'b0};
      end else begin
        so_out <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end

  // =================================================================
  // clock domain: synchronisers
  // =================================================================
  logic cs_s1, cs_s2, cs_prev;
  logic wp_s1, wp_s2;
  logic hold_s1, hold_s2;
  logic act_s1, act_s2;
  logic cs_rise;

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      cs_s1   <= cs_n_in;
      cs_s2   <= cs_s1;
      wp_s1   <= wp_n_in;
      wp_s2   <= wp_s1;
      hold_s1 <= hold_n_in;
      hold_s2 <= hold_s1;
      act_s1  <= tx_active;
      act_s2  <= act_s1;
    end
  end

  // frame results are still once chip select high has been seen
  assign cs_rise = cs_s2 && !cs_prev;

  // =================================================================
  // clock domain: latch, status, write cycle
  // =================================================================
  logic [sep_pkg::TIMER_BITS-1:0] timer, next_timer;
  logic [5:0]                     prog_idx, next_prog_idx;
  logic                           wp_fell, next_wp_fell;
  logic                           next_pin_en, next_latch, next_busy;
  logic [1:0]                     next_bp;
  logic                           next_oe;
  logic                           stat_ok, arr_ok, blocked;
  logic [1:0]                     hi_bits;

  assign hi_bits = res_addr[sep_pkg::ADDR_BITS-1:sep_pkg::ADDR_BITS-2];

  // protected blocks are whole quarters, so a page is all in or out
  always_comb begin
    case (bp)                                       // [R02]
      2'h1:    blocked = (hi_bits == 2'h3);
      2'h2:    blocked = hi_bits[1];
      2'h3:    blocked = 1'b1;
      default: blocked = 1'b0;
    endcase
  end

  // pin counts only while enabled [R16]; a fall kills the write [R14]
  assign stat_ok = latch && res_got && !res_partial
                   && (!pin_en || !wp_fell);       // [R03]
  assign arr_ok  = latch && res_got && !res_partial && !blocked;

  // next values of status and write cycle
  always_comb begin
    next_pin_en   = pin_en;
    next_bp       = bp;
    next_latch    = latch;
    next_busy     = busy;
    next_timer    = timer;
    next_prog_idx = prog_idx;
    next_wp_fell  = wp_fell;
    next_oe       = !cs_s2 && hold_s2 && act_s2;   // float in pause [R20]
    if (cs_s2) begin
      next_wp_fell = 1'b0;
    end else if (!wp_s2) begin
      next_wp_fell = 1'b1;
    end
    if (busy) begin
      // once started the cycle runs out, pin or not [R15]
      if (timer == WRITE_CYCLES[sep_pkg::TIMER_BITS-1:0] - 20'h00001) begin
        next_busy  = 1'b0;                          // [R10] [R25]
        next_latch = 1'b0;                          // [R12]
      end else begin
        next_timer = timer + 20'h00001;
      end
      if (!prog_idx[5]) begin
        next_prog_idx = prog_idx + 6'h01;
      end
    end else if (cs_rise) begin                     // [R05] [R08]
      case (res_kind)
        sep_pkg::K_SET:   next_latch = 1'b1;
        sep_pkg::K_CLEAR: next_latch = 1'b0;        // [R06]
        sep_pkg::K_WSTAT: begin
          if (stat_ok) begin                        // [R13]
            next_pin_en   = res_stat[sep_pkg::ST_PIN_EN];
            next_bp       = res_stat[sep_pkg::ST_BP_HI:sep_pkg::ST_BP_LO];
            next_busy     = 1'b1;
            next_timer    = '0;
            next_prog_idx = 6'h20;
          end
        end
        sep_pkg::K_WARRAY: begin
          if (arr_ok) begin
            next_busy     = 1'b1;
            next_timer    = '0;
            next_prog_idx = 6'h00;
          end
        end
        default: begin
          next_latch = latch;
        end
      endcase
    end
  end

  // register status and write cycle; latch clear after reset [R04]
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_en    <= sep_pkg::PIN_EN_RESET;
      bp        <= sep_pkg::BP_RESET;
      latch     <= 1'b0;
      busy      <= 1'b0;
      timer     <= '0;
      prog_idx  <= 6'h20;
      wp_fell   <= 1'b0;
      cs_prev   <= 1'b1;
      so_oe_out <= 1'b0;
    end else if (ce_in) begin
      pin_en    <= next_pin_en;
      bp        <= next_bp;
      latch     <= next_latch;
      busy      <= next_busy;
      timer     <= next_timer;
      prog_idx  <= next_prog_idx;
      wp_fell   <= next_wp_fell;
      cs_prev   <= cs_s2;
      so_oe_out <= next_oe;
    end
  end

  // program one loaded page byte per cycle at cycle start
  always_ff @(posedge clk_in) begin
    if (ce_in && busy && !prog_idx[5] && loaded[prog_idx[4:0]]) begin
      mem[{res_addr[sep_pkg::ADDR_BITS-1:sep_pkg::PAGE_BITS],
           prog_idx[4:0]}] <= page_buf[prog_idx[4:0]];
    end
  end

endmodule // sep_eeprom

// *** pkg/sep_pkg.sv ***
// =====================================================================
// shared constants of the serial eeprom command and protect logic
// =====================================================================
package sep_pkg;

  // opcodes, sent most significant bit first
  localparam logic [7:0] OPC_SET_LATCH   = 8'h06;
  localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_STAT  = 8'h01;
  localparam logic [7:0] OPC_READ_ARRAY  = 8'h03;
  localparam logic [7:0] OPC_WRITE_ARRAY = 8'h02;

  // array geometry: smaller variant, 1024 bytes, 32-byte pages
  localparam int          ADDR_BITS  = 10;
  localparam int          MEM_DEPTH  = 1024;
  localparam int          PAGE_BITS  = 5;
  localparam int          PAGE_BYTES = 32;
  localparam logic [3:0]  ADDR_LAST  = 4'hF;   // 16 address bits sent
  localparam logic [2:0]  BIT_LAST   = 3'h7;

  // status byte field positions
  localparam int          ST_PIN_EN  = 7;
  localparam int          ST_BP_HI   = 3;
  localparam int          ST_BP_LO   = 2;
  localparam int          ST_LATCH   = 1;
  localparam int          ST_BUSY    = 0;
  localparam logic [7:0]  ST_WRITE_MASK = 8'h8C;
  localparam logic [7:0]  ST_ALL_ONES   = 8'hFF;

  // values after reset
  localparam logic        PIN_EN_RESET = 1'b0;
  localparam logic [1:0]  BP_RESET     = 2'h0;

  // self-timed write cycle, longest time rounds down
  localparam int          WC_TIME_MS    = 5;
  localparam int          CLK_FREQ_KHZ  = 125000;
  localparam int          WC_CYCLES     = WC_TIME_MS * CLK_FREQ_KHZ;
  localparam int          TIMER_BITS    = 20;

  // what the last frame asked for
  typedef enum logic [2:0] {
    K_NONE,
    K_SET,
    K_CLEAR,
    K_WSTAT,
    K_WARRAY,
    K_READ
  } sep_kind_e;

endpackage

// *** sim/sep_checker.sv ***
`timescale 1ns/1ns
// =====================================================================
// port checker for the serial eeprom
// =====================================================================
module sep_checker #(
  parameter int WRITE_CYCLES = 1000
) (
  // system side
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // serial link pins
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  input wire logic so_out,
  input wire logic so_oe_out
);
  logic [7:0] op;
  logic [4:0] nb;
  logic       short_hdr;
  logic       quiet_op;
  logic       stat_live;

  // frame decode in link domain, cleared at once by chip select
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      op <= 8'h00;
      nb <= 5'h00;
    end else if (hold_n_in && nb != 5'h18) begin
      nb <= nb + 5'h01;
      op <= (nb < 5'h08) ? {op[6:0], si_in} : op;
    end
  end

  // flags move slowly, so the system clock may look at them
  assign short_hdr = !cs_n_in && (nb < 5'h08 ||
    (op == sep_pkg::OPC_READ_ARRAY && nb < 5'h18));
  assign quiet_op = nb >= 5'h08 && op != sep_pkg::OPC_READ_STATUS &&
    op != sep_pkg::OPC_READ_ARRAY;
  assign stat_live = !cs_n_in && hold_n_in && ce_in && nb >= 5'h08 &&
    op == sep_pkg::OPC_READ_STATUS;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  reset_quiet_a: assert property ($fell(rst_in) |-> !so_oe_out)
    else $error("output enabled after reset");
  idle_float_a: assert property (
    (cs_n_in && ce_in)[*4] |-> !so_oe_out)
    else $error("output driven while deselected");
  pause_float_a: assert property (
    (!hold_n_in && ce_in)[*4] |-> !so_oe_out)
    else $error("output driven during pause");
  rise_selected_a: assert property (
    $rose(so_oe_out) |-> !$past(cs_n_in, 2))
    else $error("output enabled without select");
  so_steady_a: assert property (
    !cs_n_in && !$past(cs_n_in) && sck_in && $past(sck_in)
    |-> $stable(so_out))
    else $error("output moved while clock high");
  quiet_opcode_a: assert property (quiet_op |-> !so_oe_out)
    else $error("output driven for silent opcode");
  early_drive_a: assert property (
    short_hdr[*4] |-> !so_oe_out)
    else $error("output driven before header end");
  status_drive_a: assert property (
    stat_live[*5] |-> so_oe_out)
    else $error("status not driven");
endmodule // sep_checker

bind sep_eeprom sep_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .sck_in(sck_in),
  .cs_n_in(cs_n_in), .si_in(si_in), .hold_n_in(hold_n_in),
  .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out));

// *** sim/sep_host.sv ***
`timescale 1ns/1ns
// =====================================================================
// host model driving the serial link
// =====================================================================
module sep_host (
  // link pins driven by the host
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      hold_n_out,
  // device answer
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  logic mode;
  logic last;
  logic line;

  // released line shows the inverse of the last bit, never a stale copy
  assign line = so_oe_in ? so_in : ~last;

  // idle pins; clock stands still between frames
  initial begin
    mode = 1'b0;
    last = 1'b0;
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hold_n_out = 1'b1;
  end

  // idle level picks clock mode 0 or 3
  task automatic start(input logic m);
    mode = m;
    sck_out = m;
    #40 cs_n_out = 1'b0;
    #40;
  endtask

  // si set while clock low, answer taken at the rising edge
  task automatic shift(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b0;
      si_out = tx[7-i]; // msb first
      #62;
      sck_out = 1'b1;
      rx = {rx[6:0], line};
      last = line;
      #63;
    end
  endtask

  // every command ends with a deselect and a long gap
  task automatic stop();
    if (!mode) sck_out = 1'b0;
    #40 cs_n_out = 1'b1;
    #300;
  endtask

  // pause entered and left with clock low; junk clocks inside it
  task automatic pause();
    sck_out = 1'b0;
    #20 hold_n_out = 1'b0;
    for (int i = 0; i < 4; i++) begin
      si_out = ~si_out;
      #40 sck_out = 1'b1;
      #40 sck_out = 1'b0;
    end
    #200 hold_n_out = 1'b1;
    #40;
  endtask
endmodule // sep_host

// *** sim/tb.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
// =====================================================================
// self-checking bench for the serial eeprom
// =====================================================================
module tb;
  localparam int WC = 1000; // short write cycle
  logic        clk_in;
  logic        rst_in;
  logic        ce_in;
  logic        wp_n_in;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        hold_n;
  logic        so;
  logic        so_oe;
  logic [7:0]  rx;
  logic [7:0]  ex;
  logic [15:0] a16;
  logic [7:0]  mem [0:1023];
  logic [9:0]  tbl [0:2];
  int          n;
  int          mismatches;
  int          checks;
  int          seed;

  // device and host model
  sep_eeprom #(.WRITE_CYCLES(WC)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .sck_in(sck),
    .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in),
    .so_out(so), .so_oe_out(so_oe));
  sep_host host (
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
    .so_in(so), .so_oe_in(so_oe));

  // clock, and random enable gaps that stretch the device's clock-domain timing, not the link
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) ce_in <= rst_in || (($random(seed) & 7) != 0);

  // writable unless inside the block-protect range
  function automatic logic open_at(input logic [1:0] bp, input logic [9:0] a);
    case (bp)
      2'h0: return 1'b1;
      2'h1: return a < 10'h300;
      2'h2: return a < 10'h200;
      default: return 1'b0;
    endcase
  endfunction

  // link frames
  task automatic frame_begin();
    host.start(($random(seed) & 1) != 0);
  endtask
  task automatic send(input logic [7:0] b);
    host.shift(b, 8, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    frame_begin();
    send(op);
    host.stop();
  endtask
  task automatic rd_status();
    frame_begin();
    send(sep_pkg::OPC_READ_STATUS);
    send(8'h00); // status byte comes after the opcode
    host.stop();
  endtask
  task automatic wr_status(input logic [7:0] d);
    frame_begin();
    send(sep_pkg::OPC_WRITE_STAT);
    send(d);
    host.stop();
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      rd_status();
      if (rx[0] === 1'b0) break;
    end
  endtask
  task automatic wr_array(input logic [15:0] a, input int k, input logic ok);
    logic [9:0] p;
    logic [7:0] b;
    p = a[9:0];
    frame_begin();
    send(sep_pkg::OPC_WRITE_ARRAY);
    send(a[15:8]);
    send(a[7:0]);
    for (int i = 0; i < k; i++) begin
      b = 8'($random(seed));
      send(b);
      if (ok) mem[p] = b;
      p[4:0] = p[4:0] + 5'h01; // stays in the page
    end
    host.stop();
  endtask
  task automatic rd_array(input logic [15:0] a, input int k, input logic pz);
    logic [9:0] p;
    p = a[9:0];
    frame_begin();
    send(sep_pkg::OPC_READ_ARRAY);
    send(a[15:8]);
    send(a[7:0]);
    for (int i = 0; i < k; i++) begin
      if (pz && i == 1) host.pause();
      send(8'h00);
      `CHK("array", mem[p], rx)
      p = p + 10'h001;
    end
    host.stop();
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, about a third above the expected run
  initial begin
    #790000;
    mismatches++;
    results();
  end

  initial begin
    seed = 32'h527e;
    mismatches = 0;
    checks = 0;
    rst_in = 1'b1;
    wp_n_in = 1'b1;
    tbl[0] = 10'h1FF;
    tbl[1] = 10'h2FF;
    tbl[2] = 10'h300;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    // latch commands from the reset state
    rd_status();
    `CHK("status", 8'h00, rx)
    cmd(sep_pkg::OPC_SET_LATCH);
    rd_status();
    `CHK("status", 8'h02, rx)
    cmd(sep_pkg::OPC_CLEAR_LATCH);
    wr_array(16'h0010, 1, 1'b0);
    rd_status();
    `CHK("status", 8'h00, rx)
    // unknown opcode, then a write cut inside its data byte
    cmd(8'hA5);
    cmd(sep_pkg::OPC_SET_LATCH);
    frame_begin();
    send(sep_pkg::OPC_WRITE_ARRAY);
    send(8'h00);
    send(8'h3C);
    host.shift(8'hFF, 4, rx);
    host.stop();
    rd_status();
    `CHK("status", 8'h02, rx)
    // load past the page end, then traffic during the write cycle
    wr_array(16'hFC5E, 34, 1'b1);
    rd_status();
    `CHK("status", 8'hFF, rx)
    wr_array(16'h0040, 1, 1'b0);
    wait_ready();
    `CHK("status", 8'h00, rx)
    rd_array(16'h0040, 32, 1'b1);
    // every protect code; pin low but its enable clear
    @(posedge clk_in) wp_n_in <= 1'b0;
    for (int bp = 0; bp < 4; bp++) begin
      cmd(sep_pkg::OPC_SET_LATCH);
      wr_status({4'h7, bp[1:0], 2'h3});
      wait_ready();
      `CHK("status", {4'h0, bp[1:0], 2'h0}, rx)
      for (int k = 0; k < 3; k++) begin
        cmd(sep_pkg::OPC_SET_LATCH);
        wr_array({6'h2A, tbl[k]}, 1, open_at(bp[1:0], tbl[k]));
        wait_ready();
        ex = {4'h0, bp[1:0], !open_at(bp[1:0], tbl[k]), 1'b0};
        `CHK("status", ex, rx)
        rd_array({6'h00, tbl[k]}, 1, 1'b0);
      end
    end
    // protect pin with its enable set
    @(posedge clk_in) wp_n_in <= 1'b1;
    cmd(sep_pkg::OPC_SET_LATCH);
    wr_status(8'h80);
    wait_ready();
    `CHK("status", 8'h80, rx)
    @(posedge clk_in) wp_n_in <= 1'b0;
    cmd(sep_pkg::OPC_SET_LATCH);
    wr_status(8'h8C);
    rd_status();
    `CHK("status", 8'h82, rx)
    @(posedge clk_in) wp_n_in <= 1'b1;
    frame_begin();
    send(sep_pkg::OPC_WRITE_STAT);
    @(posedge clk_in) wp_n_in <= 1'b0;
    send(8'h8C);
    host.stop();
    rd_status();
    `CHK("status", 8'h82, rx)
    @(posedge clk_in) wp_n_in <= 1'b1;
    wr_status(8'h84);
    @(posedge clk_in) wp_n_in <= 1'b0;
    wait_ready();
    `CHK("status", 8'h84, rx)
    @(posedge clk_in) wp_n_in <= 1'b1;
    cmd(sep_pkg::OPC_SET_LATCH);
    wr_status(8'h00);
    // random loads in both clock modes, top and bottom address first
    for (int i = 0; i < 6; i++) begin
      a16 = (i == 0) ? 16'hFFFF : 16'($random(seed)) & 16'hFFEF;
      a16 = (i == 1) ? 16'h0000 : a16;
      n = (i < 2) ? 1 : 1 + ($random(seed) & 3);
      wait_ready();
      cmd(sep_pkg::OPC_SET_LATCH);
      wr_array(a16, n, 1'b1);
      wait_ready();
      rd_array(a16, n, 1'b0);
    end
    rd_array(16'h03FF, 2, 1'b0); // crosses the top back to zero
    results();
  end
endmodule // tb
